/* File: include/rps_pkg.sv */
// constants and types for the ram pointer and sub-address register bank
//Behaviour
//- Command 0001 1000 restarts internal operation halted by a multiplier change.
//- Command 0000 1000 clears the receive interrupt, only while chaining is on.
//- Pointer high bit 7 picks the next RAM access: one read, zero write.
//- Pointer high bit 6 steps the pointer after each data access in the direction bit 7 picks, else it holds.
//- Pointer high bits 2-0 are RAM address bits 10 to 8.
//- Pointer low bits 7-0 are RAM address bits 7 to 0, giving 11 bits in all.
//- Pointer high bits 5-3 and sub-address bits 7-3 are reserved.
//- The sub-address field routes the indirect window to five registers.
//- The two low sub-address bits are one store seen in two registers.
//- Writing the configuration register clears the top sub-address bit.
package rps_pkg;
	localparam logic [7:0] ADDR_COMMAND   = 8'h00;
	localparam logic [7:0] ADDR_PTR_HIGH  = 8'h04;
	localparam logic [7:0] ADDR_PTR_LOW   = 8'h08;
	localparam logic [7:0] ADDR_CONFIG    = 8'h0C;
	localparam logic [7:0] ADDR_SEL       = 8'h10;
	localparam logic [7:0] ADDR_INDIRECT  = 8'h14;
	localparam logic [7:0] ADDR_RAM_DATA  = 8'h18;
	localparam logic [7:0] ADDR_STATUS    = 8'h1C;

	localparam logic [7:0] CMD_CLEAR_RX_INT = 8'h08;
	localparam logic [7:0] CMD_START_OP     = 8'h18;

	localparam int PH_READ_DIR  = 7;
	localparam int PH_AUTO_STEP = 6;
	localparam int CFG_CHAIN    = 6;
	localparam int CFG_TX_EN    = 5;
	localparam int S2_CKUP_HI   = 7;
	localparam int S2_CKUP_LO   = 6;
	localparam int ST_RUNNING   = 0;
	localparam int ST_RX_INT    = 1;

	localparam logic [7:0] RESET_BYTE  = 8'h00;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		SEL_TENTATIVE_ID = 3'b000,
		SEL_NODE_ID      = 3'b001,
		SEL_SETUP1       = 3'b010,
		SEL_NEXT_ID      = 3'b011,
		SEL_SETUP2       = 3'b100
	} rps_sel_e;

	typedef struct packed {
		logic       ram_read_direction;
		logic       pointer_auto_step;
		logic [2:0] pointer_upper_bits;
	} rps_ptr_high_s;

	typedef struct packed {
		logic       chain_enable;
		logic       tx_enable;
		logic [1:0] clock_multiplier;
		logic       running;
		logic       rx_int_pending;
	} rps_ctrl_s;
endpackage

/* File: design/rps_regs.sv */
// axi4-lite register bank: ram pointer, sub-address select, commands
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module rps_regs #(
	parameter int PTR_W = 11
) (
	input  wire logic               clock_i,
	input  wire logic               nrst_i,
	input  wire logic [7:0]         s_axi_awaddr_i,
	input  wire logic               s_axi_awvalid_i,
	output      logic               s_axi_awready_o,
	input  wire logic [31:0]        s_axi_wdata_i,
	input  wire logic [3:0]         s_axi_wstrb_i,
	input  wire logic               s_axi_wvalid_i,
	output      logic               s_axi_wready_o,
	output      logic [1:0]         s_axi_bresp_o,
	output      logic               s_axi_bvalid_o,
	input  wire logic               s_axi_bready_i,
	input  wire logic [7:0]         s_axi_araddr_i,
	input  wire logic               s_axi_arvalid_i,
	output      logic               s_axi_arready_o,
	output      logic [31:0]        s_axi_rdata_o,
	output      logic [1:0]         s_axi_rresp_o,
	output      logic               s_axi_rvalid_o,
	input  wire logic               s_axi_rready_i,
	input  wire logic               rx_event_i,
	input  wire logic [7:0]         next_id_i,
	output      logic               start_internal_o,
	output      logic               clear_rx_int_o,
	output      logic [7:0]         node_id_o,
	output      logic [PTR_W-1:0]   pointer_o,
	output      rps_pkg::rps_ctrl_s ctrl_o
);
	localparam int RAM_DEPTH = 1 << PTR_W;

	if (PTR_W < 9 || PTR_W > 11)
	begin : g_bad_width
		$error("PTR_W must lie between 9 and 11");
	end

	logic [7:0]          ram_q [RAM_DEPTH];
	rps_pkg::rps_ptr_high_s ptr_high_q;
	logic [7:0]          ptr_low_q;
	logic [PTR_W-1:0]    ptr_w;
	logic [PTR_W-1:0]    ptr_next_w;
	logic [7:2]          config_q;
	logic [1:0]          sel_low_q;
	logic                sel_top_q;
	logic [2:0]          sel_w;
	logic [7:0]          tentative_id_q;
	logic [7:0]          node_id_q;
	logic [7:0]          setup1_q;
	logic [7:0]          setup2_q;
	logic                running_q;
	logic                rx_int_q;
	logic [7:0]          aw_addr_q;
	logic                aw_have_q;
	logic [7:0]          w_data_q;
	logic                w_strb_q;
	logic                w_have_q;
	logic                wr_go;
	logic                wr_en;
	logic                rd_go;
	logic [7:0]          rd_byte;
	logic                rd_ok;
	logic                wr_ok;
	logic                ptr_step;
	logic                ram_wr;

	// write address and data are taken independently, in either order
	assign s_axi_awready_o = !aw_have_q;
	assign s_axi_wready_o  = !w_have_q;
	assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid_o;
	assign wr_en = wr_go && w_strb_q;
	// a read waits out a pending write so pointer side effects never collide
	assign s_axi_arready_o = !s_axi_rvalid_o && !wr_go;
	assign rd_go = s_axi_arvalid_i && s_axi_arready_o;

	assign ptr_w = {ptr_high_q.pointer_upper_bits, ptr_low_q};
	assign ptr_next_w = ptr_w + PTR_W'(1);
	assign sel_w = {sel_top_q, sel_low_q};

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			aw_have_q <= 1'b0;
			aw_addr_q <= rps_pkg::RESET_BYTE;
		end
		else if (s_axi_awvalid_i && s_axi_awready_o)
		begin
			aw_have_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr_i;
		end
		else if (wr_go)
			aw_have_q <= 1'b0;
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			w_have_q <= 1'b0;
			w_data_q <= rps_pkg::RESET_BYTE;
			w_strb_q <= 1'b0;
		end
		else if (s_axi_wvalid_i && s_axi_wready_o)
		begin
			w_have_q <= 1'b1;
			w_data_q <= s_axi_wdata_i[7:0];
			w_strb_q <= s_axi_wstrb_i[0];
		end
		else if (wr_go)
			w_have_q <= 1'b0;
	end

	always_comb
	begin
		wr_ok = 1'b1;
		if (aw_addr_q == rps_pkg::ADDR_COMMAND) wr_ok = 1'b1;
		else if (aw_addr_q == rps_pkg::ADDR_PTR_HIGH) wr_ok = 1'b1;
		else if (aw_addr_q == rps_pkg::ADDR_PTR_LOW) wr_ok = 1'b1;
		else if (aw_addr_q == rps_pkg::ADDR_CONFIG) wr_ok = 1'b1;
		else if (aw_addr_q == rps_pkg::ADDR_SEL) wr_ok = 1'b1;
		else if (aw_addr_q == rps_pkg::ADDR_INDIRECT) wr_ok = 1'b1;
		else if (aw_addr_q == rps_pkg::ADDR_RAM_DATA) wr_ok = 1'b1;
		else if (aw_addr_q == rps_pkg::ADDR_STATUS) wr_ok = 1'b1;
		else wr_ok = 1'b0;
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= rps_pkg::RESP_OKAY;
		end
		else if (wr_go)
		begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= wr_ok ? rps_pkg::RESP_OKAY
				: rps_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready_i)
			s_axi_bvalid_o <= 1'b0;
	end

	// data accesses honour the direction bit; the wrong direction is ignored
	assign ram_wr = wr_en && aw_addr_q == rps_pkg::ADDR_RAM_DATA
		&& !ptr_high_q.ram_read_direction;
	assign ptr_step = ptr_high_q.pointer_auto_step && (ram_wr
		|| (rd_go && s_axi_araddr_i == rps_pkg::ADDR_RAM_DATA
		&& ptr_high_q.ram_read_direction));

	always_ff @(posedge clock_i)
	begin
		if (ram_wr)
			ram_q[ptr_w] <= w_data_q;
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ptr_high_q <= '0;
			ptr_low_q  <= rps_pkg::RESET_BYTE;
		end
		else if (wr_en && aw_addr_q == rps_pkg::ADDR_PTR_HIGH)
		begin
			ptr_high_q.ram_read_direction <= w_data_q[rps_pkg::PH_READ_DIR];
			ptr_high_q.pointer_auto_step <= w_data_q[rps_pkg::PH_AUTO_STEP];
			ptr_high_q.pointer_upper_bits <= w_data_q[2:0];
		end
		else if (wr_en && aw_addr_q == rps_pkg::ADDR_PTR_LOW)
			ptr_low_q <= w_data_q;
		else if (ptr_step)
		begin
			// bits above PTR_W stay zero so the wrap lands on address zero
			ptr_high_q.pointer_upper_bits <= 3'(ptr_next_w >> 8);
			ptr_low_q <= ptr_next_w[7:0];
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			config_q  <= 6'h00;
			sel_low_q <= 2'b00;
			sel_top_q <= 1'b0;
		end
		else if (wr_en && aw_addr_q == rps_pkg::ADDR_CONFIG)
		begin
			config_q  <= w_data_q[7:2];
			sel_low_q <= w_data_q[1:0];
			sel_top_q <= 1'b0;
		end
		else if (wr_en && aw_addr_q == rps_pkg::ADDR_SEL)
		begin
			sel_low_q <= w_data_q[1:0];
			sel_top_q <= w_data_q[2];
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			tentative_id_q <= rps_pkg::RESET_BYTE;
			node_id_q      <= rps_pkg::RESET_BYTE;
			setup1_q       <= rps_pkg::RESET_BYTE;
			setup2_q       <= rps_pkg::RESET_BYTE;
		end
		else if (wr_en && aw_addr_q == rps_pkg::ADDR_INDIRECT)
		begin
			// next id is read only; reserved codes drop the write
			case (sel_w)
				rps_pkg::SEL_TENTATIVE_ID: tentative_id_q <= w_data_q;
				rps_pkg::SEL_NODE_ID:      node_id_q <= w_data_q;
				rps_pkg::SEL_SETUP1:       setup1_q <= w_data_q;
				rps_pkg::SEL_SETUP2:       setup2_q <= w_data_q;
				default:                   ;
			endcase
		end
	end

	// a multiplier change halts internal work until the start command
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			running_q <= 1'b1;
		else if (wr_en && aw_addr_q == rps_pkg::ADDR_COMMAND
			&& w_data_q == rps_pkg::CMD_START_OP)
			running_q <= 1'b1;
		else if (wr_en && aw_addr_q == rps_pkg::ADDR_INDIRECT
			&& sel_w == rps_pkg::SEL_SETUP2
			&& (w_data_q[rps_pkg::S2_CKUP_HI] != setup2_q[rps_pkg::S2_CKUP_HI]
			|| w_data_q[rps_pkg::S2_CKUP_LO]
			!= setup2_q[rps_pkg::S2_CKUP_LO]))
			running_q <= 1'b0;
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			start_internal_o <= 1'b0;
			clear_rx_int_o   <= 1'b0;
		end
		else
		begin
			start_internal_o <= wr_en && aw_addr_q == rps_pkg::ADDR_COMMAND
				&& w_data_q == rps_pkg::CMD_START_OP;
			clear_rx_int_o <= wr_en && aw_addr_q == rps_pkg::ADDR_COMMAND
				&& w_data_q == rps_pkg::CMD_CLEAR_RX_INT
				&& config_q[rps_pkg::CFG_CHAIN];
		end
	end

	// a receive event in the clearing cycle keeps the flag set
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rx_int_q <= 1'b0;
		else if (rx_event_i)
			rx_int_q <= 1'b1;
		else if (wr_en && aw_addr_q == rps_pkg::ADDR_COMMAND
			&& w_data_q == rps_pkg::CMD_CLEAR_RX_INT
			&& config_q[rps_pkg::CFG_CHAIN])
			rx_int_q <= 1'b0;
	end

	always_comb
	begin
		rd_byte = rps_pkg::RESET_BYTE;
		rd_ok = 1'b1;
		if (s_axi_araddr_i == rps_pkg::ADDR_COMMAND)
			rd_byte = rps_pkg::RESET_BYTE;
		else if (s_axi_araddr_i == rps_pkg::ADDR_PTR_HIGH)
			rd_byte = {ptr_high_q.ram_read_direction,
				ptr_high_q.pointer_auto_step, 3'b000,
				ptr_high_q.pointer_upper_bits};
		else if (s_axi_araddr_i == rps_pkg::ADDR_PTR_LOW)
			rd_byte = ptr_low_q;
		else if (s_axi_araddr_i == rps_pkg::ADDR_CONFIG)
			rd_byte = {config_q, sel_low_q};
		else if (s_axi_araddr_i == rps_pkg::ADDR_SEL)
			rd_byte = {5'b00000, sel_w};
		else if (s_axi_araddr_i == rps_pkg::ADDR_INDIRECT)
		begin
			case (sel_w)
				rps_pkg::SEL_TENTATIVE_ID: rd_byte = tentative_id_q;
				rps_pkg::SEL_NODE_ID:      rd_byte = node_id_q;
				rps_pkg::SEL_SETUP1:       rd_byte = setup1_q;
				rps_pkg::SEL_NEXT_ID:      rd_byte = next_id_i;
				rps_pkg::SEL_SETUP2:       rd_byte = setup2_q;
				default:                   rd_byte = rps_pkg::RESET_BYTE;
			endcase
		end
		else if (s_axi_araddr_i == rps_pkg::ADDR_RAM_DATA)
			rd_byte = ptr_high_q.ram_read_direction ? ram_q[ptr_w]
				: rps_pkg::RESET_BYTE;
		else if (s_axi_araddr_i == rps_pkg::ADDR_STATUS)
		begin
			rd_byte = rps_pkg::RESET_BYTE;
			rd_byte[rps_pkg::ST_RUNNING] = running_q;
			rd_byte[rps_pkg::ST_RX_INT] = rx_int_q;
		end
		else
			rd_ok = 1'b0;
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h0000_0000;
			s_axi_rresp_o  <= rps_pkg::RESP_OKAY;
		end
		else if (rd_go)
		begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o  <= {24'h00_0000, rd_byte};
			s_axi_rresp_o  <= rd_ok ? rps_pkg::RESP_OKAY
				: rps_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready_i)
			s_axi_rvalid_o <= 1'b0;
	end

	assign node_id_o = node_id_q;
	assign pointer_o = ptr_w;
	assign ctrl_o = '{chain_enable: config_q[rps_pkg::CFG_CHAIN],
		tx_enable: config_q[rps_pkg::CFG_TX_EN],
		clock_multiplier: {setup2_q[rps_pkg::S2_CKUP_HI],
		setup2_q[rps_pkg::S2_CKUP_LO]},
		running: running_q,
		rx_int_pending: rx_int_q};
endmodule // rps_regs

/* File: test/rps_host.sv */
// host model: axi4-lite master on the register port
`timescale 1ns/10ps
module rps_host (
	input  wire logic       clock_i,
	output      logic [7:0] addr_o,
	output      logic [7:0] wdata_o,
	output      logic       awvalid_o,
	output      logic       wvalid_o,
	output      logic       bready_o,
	output      logic       arvalid_o,
	output      logic       rready_o,
	input  wire logic       awready_i,
	input  wire logic       wready_i,
	input  wire logic       bvalid_i,
	input  wire logic       arready_i,
	input  wire logic       rvalid_i,
	input  wire logic [7:0] rdata_i,
	input  wire logic [1:0] resp_i
);
	logic       tmo = 0;
	logic [7:0] rd_q;
	logic [1:0] resp_q;
	initial {addr_o, wdata_o, awvalid_o, wvalid_o, bready_o} = 19'h0_0000;
	initial {arvalid_o, rready_o} = 2'h0;
	// leading edge keeps a release and a raise out of one time step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clock_i);
		{addr_o, wdata_o} <= {a, d};
		{awvalid_o, wvalid_o, bready_o} <= 3'h7;
		for (n = 0; n < 40 && !bvalid_i; n++)
		begin
			@(posedge clock_i);
			if (awready_i) awvalid_o <= 0;
			if (wready_i) wvalid_o <= 0;
		end
		resp_q = resp_i;
		bready_o <= 0;
		tmo |= n == 40;
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge clock_i);
		addr_o <= a;
		{arvalid_o, rready_o} <= 2'h3;
		for (n = 0; n < 40 && !rvalid_i; n++)
		begin
			@(posedge clock_i);
			if (arready_i) arvalid_o <= 0;
		end
		{rd_q, resp_q} = {rdata_i, resp_i};
		rready_o <= 0;
		tmo |= n == 40;
	endtask
endmodule // rps_host

/* File: test/rps_regs_props.sv */
// port assertions for the register bank
`timescale 1ns/10ps
module rps_regs_props #(
	parameter int PTR_W = 11
) (
	input wire logic               clock_i,
	input wire logic               nrst_i,
	input wire logic               s_axi_awvalid_i,
	input wire logic               s_axi_awready_o,
	input wire logic               s_axi_wvalid_i,
	input wire logic               s_axi_wready_o,
	input wire logic               s_axi_bvalid_o,
	input wire logic               s_axi_arvalid_i,
	input wire logic               s_axi_arready_o,
	input wire logic [31:0]        s_axi_rdata_o,
	input wire logic               s_axi_rvalid_o,
	input wire logic               start_internal_o,
	input wire logic               clear_rx_int_o,
	input wire logic [PTR_W-1:0]   pointer_o,
	input wire rps_pkg::rps_ctrl_s ctrl_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!nrst_i);
	sequence aw_w_taken;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence ar_taken;
		s_axi_arvalid_i && s_axi_arready_o;
	endsequence
	chk_write_answer:
		assert property (aw_w_taken |=> ##1 s_axi_bvalid_o)
		else $error("write not answered");
	chk_ready_drop:
		assert property (aw_w_taken |=> !s_axi_awready_o && !s_axi_wready_o)
		else $error("ready not dropped");
	chk_read_answer:
		assert property (ar_taken |=> s_axi_rvalid_o)
		else $error("read not answered");
	chk_upper_zero:
		assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	chk_start_pulse:
		assert property (start_internal_o |-> s_axi_bvalid_o
			##1 (!start_internal_o && ctrl_o.running))
		else $error("start pulse wrong");
	chk_mult_halts:
		assert property ($changed(ctrl_o.clock_multiplier)
			|-> ##[0:1] !ctrl_o.running)
		else $error("multiplier change did not halt");
	chk_clear_gated:
		assert property (clear_rx_int_o |-> ctrl_o.chain_enable && s_axi_bvalid_o)
		else $error("clear pulse without chaining");
	chk_ptr_cause:
		assert property (!$stable(pointer_o)
			|-> $past(s_axi_arvalid_i && s_axi_arready_o) || $rose(s_axi_bvalid_o))
		else $error("pointer moved without access");
endmodule // rps_regs_props
bind rps_regs rps_regs_props #(.PTR_W(PTR_W)) chk_i (.*);

/* File: test/rps_regs_tb.sv */
// self-checking bench for the register bank
`timescale 1ns/10ps
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin \
	errors++; $display("MISMATCH %0t %s", $time, m); end end
module rps_regs_tb;
	logic clock_i = 0;
	logic nrst_i = 0;
	logic rx_event_i = 0;
	logic [7:0] next_id_i = 8'h00;
	logic [7:0] addr, wdata, node_id, h, l;
	logic awv, wv, brdy, arv, rrdy, awr, wrdy, bv, arr, rv, start, clr;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [10:0] ptr;
	rps_pkg::rps_ctrl_s ctrl;
	int errors = 0;
	int check_count = 0;
	int n_start = 0;
	int n_clr = 0;
	logic [31:0] seed = 32'h0000_001E;
	always #25 clock_i = ~clock_i;
	always @(posedge clock_i)
	begin
		if (start) n_start++;
		if (clr) n_clr++;
		if (host.tmo)
		begin
			errors++;
			test_done();
		end
	end
	rps_regs uut (
		.clock_i(clock_i), .nrst_i(nrst_i), .s_axi_awaddr_i(addr),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
		.s_axi_wdata_i({24'h00_0000, wdata}), .s_axi_wstrb_i(4'hF),
		.s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bv), .s_axi_bready_i(brdy), .s_axi_araddr_i(addr),
		.s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrdy),
		.rx_event_i(rx_event_i), .next_id_i(next_id_i),
		.start_internal_o(start), .clear_rx_int_o(clr),
		.node_id_o(node_id), .pointer_o(ptr), .ctrl_o(ctrl));
	rps_host host (
		.clock_i(clock_i), .addr_o(addr), .wdata_o(wdata), .awvalid_o(awv),
		.wvalid_o(wv), .bready_o(brdy), .arvalid_o(arv), .rready_o(rrdy),
		.awready_i(awr), .wready_i(wrdy), .bvalid_i(bv), .arready_i(arr),
		.rvalid_i(rv), .rdata_i(rdata[7:0]), .resp_i(rv ? rresp : bresp));
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// reserved middle bits of the high byte read as zero
	function automatic logic [7:0] hi_view(input logic [7:0] v);
		return v & 8'hC7;
	endfunction
	task automatic rchk(input logic [7:0] a, input logic [7:0] e, string m);
		host.rd(a);
		`CHK(host.rd_q, e, m)
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge clock_i);
		nrst_i <= 1;
		rchk(rps_pkg::ADDR_STATUS, 8'h01, "status reset");
		repeat (6)
		begin
			h = rnd();
			l = rnd();
			host.wr(rps_pkg::ADDR_PTR_HIGH, h);
			host.wr(rps_pkg::ADDR_PTR_LOW, l);
			rchk(rps_pkg::ADDR_PTR_HIGH, hi_view(h), "high");
			`CHK(ptr, {h[2:0], l}, "pointer")
		end
		host.wr(rps_pkg::ADDR_PTR_HIGH, 8'h07);
		host.wr(rps_pkg::ADDR_PTR_LOW, 8'hFF);
		host.wr(rps_pkg::ADDR_RAM_DATA, 8'h3C);
		`CHK(ptr, 11'h7FF, "held")
		host.wr(rps_pkg::ADDR_PTR_HIGH, 8'h47);
		host.wr(rps_pkg::ADDR_RAM_DATA, 8'hA5);
		`CHK(ptr, 11'h000, "wrap")
		host.wr(rps_pkg::ADDR_PTR_HIGH, 8'hC7);
		host.wr(rps_pkg::ADDR_PTR_LOW, 8'hFF);
		host.wr(rps_pkg::ADDR_RAM_DATA, 8'h11);
		rchk(rps_pkg::ADDR_RAM_DATA, 8'hA5, "ram read");
		`CHK(ptr, 11'h000, "read step")
		host.wr(rps_pkg::ADDR_PTR_HIGH, 8'h40);
		host.wr(rps_pkg::ADDR_PTR_LOW, 8'hFF);
		host.wr(rps_pkg::ADDR_RAM_DATA, 8'h5A);
		`CHK(ptr, 11'h100, "carry")
		host.wr(rps_pkg::ADDR_SEL, 8'hFF);
		rchk(rps_pkg::ADDR_SEL, 8'h07, "select view");
		rchk(rps_pkg::ADDR_CONFIG, 8'h03, "shared bits");
		host.wr(rps_pkg::ADDR_CONFIG, 8'h41);
		rchk(rps_pkg::ADDR_SEL, 8'h01, "top cleared");
		host.wr(rps_pkg::ADDR_INDIRECT, 8'h5A);
		`CHK(node_id, 8'h5A, "node id")
		next_id_i <= rnd();
		host.wr(rps_pkg::ADDR_CONFIG, 8'h43);
		rchk(rps_pkg::ADDR_INDIRECT, next_id_i, "next id");
		host.wr(rps_pkg::ADDR_SEL, 8'h04);
		host.wr(rps_pkg::ADDR_INDIRECT, 8'h80);
		rchk(rps_pkg::ADDR_STATUS, 8'h00, "halted");
		host.wr(rps_pkg::ADDR_COMMAND, rps_pkg::CMD_START_OP);
		repeat (2) @(posedge clock_i);
		`CHK(n_start, 1, "start pulse")
		`CHK(ctrl.running, 1'b1, "running")
		rx_event_i <= 1;
		@(posedge clock_i);
		rx_event_i <= 0;
		rchk(rps_pkg::ADDR_STATUS, 8'h03, "rx flag");
		host.wr(rps_pkg::ADDR_COMMAND, rps_pkg::CMD_CLEAR_RX_INT);
		repeat (2) @(posedge clock_i);
		`CHK(n_clr, 1, "clear pulse")
		`CHK(ctrl.rx_int_pending, 1'b0, "rx cleared")
		host.wr(rps_pkg::ADDR_CONFIG, 8'h00);
		host.wr(rps_pkg::ADDR_COMMAND, rps_pkg::CMD_CLEAR_RX_INT);
		repeat (2) @(posedge clock_i);
		`CHK(n_clr, 1, "unchained clear")
		host.wr(8'h20, 8'h00);
		`CHK(host.resp_q, rps_pkg::RESP_SLVERR, "unmapped write")
		rchk(8'h20, 8'h00, "unmapped read");
		`CHK(host.resp_q, rps_pkg::RESP_SLVERR, "unmapped resp")
		test_done();
	end
endmodule // rps_regs_tb
